/* tcp_pkg.sv */
package tcp_pkg;

	// Fixed slave address, pattern 0101 110
	localparam logic [6:0] DEV_ADDR = 7'h2e;

	// Register address pointer
	localparam int PTR_W = 10;
	localparam logic [9:0] PTR_MAX = 10'h3ff;
	localparam logic [9:0] PTR_RST = 10'h000;

	// Byte roles seen by the device while receiving
	localparam logic [2:0] ROLE_ADDR = 3'h0;
	localparam logic [2:0] ROLE_AHI = 3'h1;
	localparam logic [2:0] ROLE_ALO = 3'h2;
	localparam logic [2:0] ROLE_DHI = 3'h3;
	localparam logic [2:0] ROLE_DLO = 3'h4;

	// Bit counter marks inside one nine-clock byte
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_END = 4'h9;

	// Host step numbers in one transaction
	localparam logic [2:0] STEP_AHI = 3'h1;
	localparam logic [2:0] STEP_ALO = 3'h2;
	localparam logic [2:0] STEP_DHI = 3'h3;
	localparam logic [2:0] STEP_WLAST = 3'h4;
	localparam logic [2:0] STEP_RHI = 3'h4;
	localparam logic [2:0] STEP_RLO = 3'h5;

	// Timing: core clock and the serial clock the host makes
	localparam int CLK_MHZ = 100;
	localparam int SCL_PERIOD_NS = 2500;
	localparam int QTR_CYC = SCL_PERIOD_NS * CLK_MHZ / 4000;
	localparam logic [7:0] QTR_CNT = 8'(QTR_CYC - 1);

	// Read data buffer shape
	localparam int FIFO_W = 16;
	localparam int FIFO_D = 8;

	typedef enum logic [3:0] {
		DS_IDLE = 4'b0001,
		DS_RX = 4'b0010,
		DS_TX = 4'b0100,
		DS_HOLD = 4'b1000
	} tcp_dstate_t;

	typedef enum logic [4:0] {
		HS_IDLE = 5'b00001,
		HS_START = 5'b00010,
		HS_BIT = 5'b00100,
		HS_PUSH = 5'b01000,
		HS_STOP = 5'b10000
	} tcp_hstate_t;

endpackage

/* tcp_bus_if.sv */
`timescale 1ns/1ps
interface tcp_bus_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Open-drain wires with pull-ups
	assign scl = host_scl_oe ? host_scl_o : 1'b1;
	assign sda = (host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o) ? 1'b0 : 1'b1;

	modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
	modport dev (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface

/* tcp_dev_end.sv */
`timescale 1ns/1ps
module tcp_dev_end (
	input wire logic core_clk, // System clock
	input wire logic rst, // Synchronous reset
	tcp_bus_if.dev bus, // Two-wire bus
	output logic [9:0] reg_addr_q, // Register address
	output logic [15:0] reg_wdata_q, // Register write data
	output logic reg_wr_q, // Write strobe
	output logic reg_rd_q, // Read fetch strobe
	input wire logic [15:0] reg_rdata // Register read data
);

	logic scl_s1_q, scl_s2_q, scl_d_q;
	logic sda_s1_q, sda_s2_q, sda_d_q;
	logic scl_rise, scl_fall, start_ev, stop_ev;
	logic [3:0] bit_q;
	logic [7:0] shift_q;
	tcp_pkg::tcp_dstate_t state_q;
	logic [2:0] role_q;
	logic [9:0] ptr_q;
	logic [9:0] ptr_nxt;
	logic full_q;
	logic half_q;
	logic [7:0] hi_q;
	logic [15:0] word_q;
	logic [7:0] cur_byte;
	logic [2:0] tx_idx;
	logic sda_oe_q;
	logic [1:0] fetch_q;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detect
	always_ff @(posedge core_clk) begin
		if (rst) begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_d_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_d_q <= 1'b1;
		end else begin
			scl_s1_q <= bus.scl;
			scl_s2_q <= scl_s1_q;
			scl_d_q <= scl_s2_q;
			sda_s1_q <= bus.sda;
			sda_s2_q <= sda_s1_q;
			sda_d_q <= sda_s2_q;
		end
	end

	// Clock edges and bus conditions
	assign scl_rise = scl_s2_q & ~scl_d_q;
	assign scl_fall = ~scl_s2_q & scl_d_q;
	assign start_ev = scl_s2_q & scl_d_q & sda_d_q & ~sda_s2_q;
	assign stop_ev = scl_s2_q & scl_d_q & ~sda_d_q & sda_s2_q;

	////////////////////////////////////////////////////////////////////////////////
	// Bit counter and input shifter
	always_ff @(posedge core_clk) begin
		if (rst || start_ev || stop_ev) begin
			bit_q <= 4'h0;
			shift_q <= 8'h00;
		end else if (scl_rise) begin
			shift_q <= {shift_q[6:0], sda_s2_q};
			if (bit_q != tcp_pkg::BIT_END) begin
				bit_q <= bit_q + 4'h1;
			end
		end else if (scl_fall && bit_q == tcp_pkg::BIT_END) begin
			bit_q <= 4'h0;
		end
	end

	// Next pointer and byte being sent
	// ten-bit top limit
	assign ptr_nxt = (ptr_q == tcp_pkg::PTR_MAX) ? ptr_q : ptr_q + 10'h001;
	assign cur_byte = half_q ? word_q[7:0] : word_q[15:8];
	assign tx_idx = (bit_q == tcp_pkg::BIT_END) ? 3'h7 : 3'(4'h7 - bit_q);

	////////////////////////////////////////////////////////////////////////////////
	// Protocol state, pointer, strobes and data drive
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= tcp_pkg::DS_IDLE;
			role_q <= tcp_pkg::ROLE_ADDR;
			ptr_q <= tcp_pkg::PTR_RST;
			full_q <= 1'b0;
			half_q <= 1'b0;
			hi_q <= 8'h00;
			sda_oe_q <= 1'b0;
			reg_addr_q <= 10'h000;
			reg_wdata_q <= 16'h0000;
			reg_wr_q <= 1'b0;
			reg_rd_q <= 1'b0;
		end else begin
			reg_wr_q <= 1'b0;
			reg_rd_q <= 1'b0;
			if (stop_ev) begin
				state_q <= tcp_pkg::DS_IDLE;
				ptr_q <= tcp_pkg::PTR_RST;
				full_q <= 1'b0;
				sda_oe_q <= 1'b0;
			end else if (start_ev) begin
				state_q <= tcp_pkg::DS_RX;
				role_q <= tcp_pkg::ROLE_ADDR;
				half_q <= 1'b0;
				sda_oe_q <= 1'b0;
			end else begin
				unique case (state_q)
					tcp_pkg::DS_IDLE, tcp_pkg::DS_HOLD: begin
						sda_oe_q <= 1'b0;
					end
					tcp_pkg::DS_RX: begin
						if (scl_fall && bit_q == tcp_pkg::BIT_END) begin
							sda_oe_q <= 1'b0;
						end else if (scl_fall && bit_q == tcp_pkg::BIT_ACK) begin
							sda_oe_q <= 1'b1;
							unique case (role_q)
								tcp_pkg::ROLE_ADDR: begin
									if (shift_q[7:1] != tcp_pkg::DEV_ADDR) begin
										state_q <= tcp_pkg::DS_IDLE;
										sda_oe_q <= 1'b0;
									end else if (shift_q[0]) begin
										state_q <= tcp_pkg::DS_TX;
										half_q <= 1'b0;
										reg_addr_q <= ptr_q;
										reg_rd_q <= 1'b1;
									end else begin
										role_q <= tcp_pkg::ROLE_AHI;
									end
								end
								tcp_pkg::ROLE_AHI: begin
									ptr_q[9:8] <= shift_q[1:0];
									role_q <= tcp_pkg::ROLE_ALO;
								end
								tcp_pkg::ROLE_ALO: begin
									ptr_q[7:0] <= shift_q;
									full_q <= 1'b0;
									role_q <= tcp_pkg::ROLE_DHI;
								end
								tcp_pkg::ROLE_DHI: begin
									hi_q <= shift_q;
									role_q <= tcp_pkg::ROLE_DLO;
								end
								default: begin
									if (!full_q) begin
										reg_addr_q <= ptr_q;
										reg_wdata_q <= {hi_q, shift_q};
										reg_wr_q <= 1'b1;
										if (ptr_q == tcp_pkg::PTR_MAX) begin
											full_q <= 1'b1;
										end else begin
											ptr_q <= ptr_q + 10'h001;
										end
									end
									role_q <= tcp_pkg::ROLE_DHI;
								end
							endcase
						end
					end
					default: begin
						if (scl_fall && bit_q == tcp_pkg::BIT_ACK) begin
							sda_oe_q <= 1'b0;
						end else if (scl_fall) begin
							sda_oe_q <= ~cur_byte[tx_idx];
						end else if (scl_rise && bit_q == tcp_pkg::BIT_ACK && !sda_oe_q) begin // Own ack skipped
							if (sda_s2_q) begin
								state_q <= tcp_pkg::DS_HOLD;
							end else if (!half_q) begin
								half_q <= 1'b1;
							end else begin
								half_q <= 1'b0;
								ptr_q <= ptr_nxt;
								reg_addr_q <= ptr_nxt;
								reg_rd_q <= 1'b1;
							end
						end
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data capture two cycles after fetch
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fetch_q <= 2'b00;
			word_q <= 16'h0000;
		end else begin
			fetch_q <= {fetch_q[0], reg_rd_q};
			if (fetch_q[1]) begin
				word_q <= reg_rdata;
			end
		end
	end

	// Open-drain data pin, only ever pulls low
	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe = sda_oe_q;

endmodule // tcp_dev_end

/* tcp_host_end.sv */
`timescale 1ns/1ps
module tcp_fifo #(
	parameter int W = 16,
	parameter int D = 8
) (
	input wire logic core_clk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic in_valid, // Write request
	output logic in_ready, // Space free
	input wire logic [W-1:0] in_data, // Write word
	output logic out_valid, // Word available
	input wire logic out_ready, // Consumer takes word
	output logic [W-1:0] out_data // Head word
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] DEPTH = (AW + 1)'(D);
	logic [W-1:0] mem_q [D];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0] cnt_q;
	logic push, pop;

	assign in_ready = cnt_q != DEPTH;
	assign out_valid = cnt_q != '0;
	assign out_data = mem_q[rp_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Storage
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + AW'(1);
			end
			if (pop) begin
				rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + AW'(1);
			end
			cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule // tcp_fifo

////////////////////////////////////////////////////////////////////////////////
module tcp_host_end (
	input wire logic core_clk, // System clock
	input wire logic rst, // Synchronous reset
	tcp_bus_if.host bus, // Two-wire bus
	input wire logic cmd_valid, // Command offered
	output logic cmd_ready_q, // Idle, takes command
	input wire logic cmd_read, // 1 read, 0 write
	input wire logic [9:0] cmd_addr, // Register address
	input wire logic [15:0] cmd_wdata, // Write value
	output logic rd_valid, // Read word waiting
	input wire logic rd_ready, // Read word taken
	output logic [15:0] rd_data, // Read word
	output logic nack_err_q // Pulse on missing ack
);

	tcp_pkg::tcp_hstate_t state_q;
	logic [7:0] qcnt_q;
	logic tick;
	logic [1:0] ph_q;
	logic [3:0] bit_q;
	logic [2:0] step_q;
	logic rd_mode_q;
	logic [9:0] addr_q;
	logic [15:0] wdata_q, word_q;
	logic [7:0] shift_q;
	logic ack_q;
	logic scl_oe_q, sda_oe_q, nack_set;
	logic sda_s1_q, sda_s2_q;
	logic rx_byte;
	logic [7:0] tx_byte;
	logic push_ready;

	////////////////////////////////////////////////////////////////////////////////
	// Data pin synchroniser
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
		end else begin
			sda_s1_q <= bus.sda;
			sda_s2_q <= sda_s1_q;
		end
	end

	// Quarter-period divider for the serial clock
	assign tick = qcnt_q == tcp_pkg::QTR_CNT;
	always_ff @(posedge core_clk) begin
		if (rst || state_q == tcp_pkg::HS_IDLE || state_q == tcp_pkg::HS_PUSH) begin
			qcnt_q <= 8'h00;
		end else begin
			qcnt_q <= tick ? 8'h00 : qcnt_q + 8'h01;
		end
	end

	// Byte to send for each step
	assign rx_byte = rd_mode_q && step_q >= tcp_pkg::STEP_RHI;
	always_comb begin
		unique case (step_q)
			3'h0: tx_byte = {tcp_pkg::DEV_ADDR, 1'b0};
			tcp_pkg::STEP_AHI: tx_byte = {6'h00, addr_q[9:8]};
			tcp_pkg::STEP_ALO: tx_byte = addr_q[7:0];
			tcp_pkg::STEP_DHI: tx_byte = rd_mode_q ? {tcp_pkg::DEV_ADDR, 1'b1} : wdata_q[15:8];
			tcp_pkg::STEP_WLAST: tx_byte = wdata_q[7:0];
			default: tx_byte = 8'hff;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transaction sequencer and pin drive
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= tcp_pkg::HS_IDLE;
			cmd_ready_q <= 1'b1;
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			step_q <= 3'h0;
			rd_mode_q <= 1'b0;
			addr_q <= 10'h000;
			wdata_q <= 16'h0000;
			word_q <= 16'h0000;
			shift_q <= 8'h00;
			ack_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			nack_err_q <= 1'b0;
		end else begin
			nack_err_q <= 1'b0;
			unique case (state_q)
				tcp_pkg::HS_IDLE: begin
					scl_oe_q <= 1'b0;
					sda_oe_q <= 1'b0;
					if (cmd_valid && cmd_ready_q) begin
						cmd_ready_q <= 1'b0;
						rd_mode_q <= cmd_read;
						addr_q <= cmd_addr;
						wdata_q <= cmd_wdata;
						step_q <= 3'h0;
						ph_q <= 2'h0;
						state_q <= tcp_pkg::HS_START;
					end
				end
				tcp_pkg::HS_START: begin
					if (tick) begin
						ph_q <= ph_q + 2'h1;
						unique case (ph_q)
							2'h0: begin
								sda_oe_q <= 1'b0;
								scl_oe_q <= 1'b1;
							end
							2'h1: scl_oe_q <= 1'b0;
							// Start or repeated start: data falls, clock high
							// start condition
							2'h2: sda_oe_q <= 1'b1;
							default: begin
								scl_oe_q <= 1'b1;
								bit_q <= 4'h0;
								state_q <= tcp_pkg::HS_BIT;
							end
						endcase
					end
				end
				tcp_pkg::HS_BIT: begin
					if (tick) begin
						ph_q <= ph_q + 2'h1;
						unique case (ph_q)
							2'h0: begin
								if (bit_q < tcp_pkg::BIT_ACK) begin
									sda_oe_q <= ~rx_byte & ~tx_byte[3'(4'h7 - bit_q)];
								end else begin
									// Ack first read byte, nack the last
									sda_oe_q <= rx_byte && step_q == tcp_pkg::STEP_RHI;
								end
							end
							2'h1: scl_oe_q <= 1'b0;
							2'h2: begin
								if (bit_q < tcp_pkg::BIT_ACK) begin
									shift_q <= {shift_q[6:0], sda_s2_q};
								end else begin
									ack_q <= sda_s2_q;
								end
							end
							default: begin
								scl_oe_q <= 1'b1;
								if (bit_q < tcp_pkg::BIT_ACK) begin
									bit_q <= bit_q + 4'h1;
								end else begin
									bit_q <= 4'h0;
									step_q <= step_q + 3'h1;
									if (!rx_byte && ack_q) begin
										nack_err_q <= 1'b1;
										state_q <= tcp_pkg::HS_STOP;
									end else if (!rd_mode_q && step_q == tcp_pkg::STEP_WLAST) begin
										state_q <= tcp_pkg::HS_STOP;
									end else if (rd_mode_q && step_q == tcp_pkg::STEP_ALO) begin
										state_q <= tcp_pkg::HS_START;
									end else if (rd_mode_q && step_q == tcp_pkg::STEP_RHI) begin
										word_q[15:8] <= shift_q;
									end else if (rd_mode_q && step_q == tcp_pkg::STEP_RLO) begin
										word_q[7:0] <= shift_q;
										state_q <= tcp_pkg::HS_PUSH;
									end
								end
							end
						endcase
					end
				end
				tcp_pkg::HS_PUSH: begin
					// Clock held low until the buffer has room
					sda_oe_q <= 1'b0;
					if (push_ready) begin
						ph_q <= 2'h0;
						state_q <= tcp_pkg::HS_STOP;
					end
				end
				default: begin
					if (tick) begin
						ph_q <= ph_q + 2'h1;
						unique case (ph_q)
							2'h0: begin
								sda_oe_q <= 1'b1;
								scl_oe_q <= 1'b1;
							end
							2'h1: scl_oe_q <= 1'b0;
							// Stop: data rises while clock high
							// stop ends transfer
							2'h2: sda_oe_q <= 1'b0;
							default: begin
								cmd_ready_q <= 1'b1;
								state_q <= tcp_pkg::HS_IDLE;
							end
						endcase
					end
				end
			endcase
		end
	end

	// Read word buffer toward the user
	tcp_fifo #(.W(tcp_pkg::FIFO_W), .D(tcp_pkg::FIFO_D)) u_rd_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(state_q == tcp_pkg::HS_PUSH),
		.in_ready(push_ready),
		.in_data(word_q),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	// Open-drain pins, only ever pull low
	assign bus.host_scl_o = 1'b0;
	assign bus.host_scl_oe = scl_oe_q;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_sda_oe = sda_oe_q;

endmodule // tcp_host_end

/* tcp_bus_asserts.sv */
`timescale 1ns/1ps
module tcp_bus_asserts (
	input wire logic core_clk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic host_scl_o, // Host clock value
	input wire logic host_scl_oe, // Host pulls clock low
	input wire logic host_sda_o, // Host data value
	input wire logic host_sda_oe, // Host pulls data low
	input wire logic dev_sda_o, // Device data value
	input wire logic dev_sda_oe, // Device pulls data low
	input wire logic scl, // Resolved clock wire
	input wire logic sda // Resolved data wire
);
	logic scl_p;
	logic sda_p;
	logic busy_q;
	logic rd_q;
	logic [3:0] cnt_q;
	logic [2:0] idx_q;
	logic [7:0] sh_q;
	logic rise;
	logic start_w;
	logic stop_w;

	// Wire events
	assign rise = scl & ~scl_p;
	assign start_w = scl & scl_p & sda_p & ~sda;
	assign stop_w = scl & scl_p & ~sda_p & sda;

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////////
	// Previous wire levels
	always_ff @(posedge core_clk) begin
		scl_p <= scl;
		sda_p <= sda;
	end

	// Frame open between start and stop
	always_ff @(posedge core_clk) begin
		if (rst || stop_w) begin
			busy_q <= 1'b0;
		end else if (start_w) begin
			busy_q <= 1'b1;
		end
	end

	// Bit, byte and direction tracking
	always_ff @(posedge core_clk) begin
		if (rst || start_w) begin
			cnt_q <= 4'h0;
			idx_q <= 3'h0;
			rd_q <= 1'b0;
			sh_q <= 8'h00;
		end else if (rise) begin
			sh_q <= {sh_q[6:0], sda};
			cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
			if (cnt_q == 4'h8) begin
				idx_q <= idx_q + 3'h1;
			end
			if (cnt_q == 4'h8 && idx_q == 3'h0) begin
				rd_q <= sh_q[0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	a_dev_drive_busy: assert property (dev_sda_oe |-> busy_q)
		else $error("device drove data outside a frame");
	a_addr_ack_low: assert property (rise && cnt_q == 4'h8 && idx_q == 3'h0
		&& sh_q[7:1] == tcp_pkg::DEV_ADDR |-> !sda)
		else $error("own address not acknowledged");
	a_write_byte_ack: assert property (rise && cnt_q == 4'h8 && idx_q != 3'h0 && !rd_q |-> !sda)
		else $error("write byte not acknowledged");
	a_rd_hi_ack: assert property (rise && cnt_q == 4'h8 && rd_q && idx_q == 3'h1 |-> !sda)
		else $error("host did not acknowledge high byte");
	a_rd_nack_stop: assert property (rise && cnt_q == 4'h8 && rd_q && idx_q == 3'h2
		|-> sda ##[1:1000] stop_w)
		else $error("read not closed by no-ack and stop");
	a_dev_quiet_rx: assert property (scl && !rise && cnt_q != 4'h0 && !rd_q |-> !dev_sda_oe)
		else $error("device drove data while receiving");
	a_host_quiet_rd: assert property (scl && !rise && cnt_q != 4'h0 && rd_q
		&& (idx_q == 3'h1 || idx_q == 3'h2) |-> !host_sda_oe)
		else $error("host drove data during read byte");
	a_dev_change_low: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("device changed data while clock high");
endmodule // tcp_bus_asserts

/* tb.sv */
`timescale 1ns/1ps
module tb;
	logic core_clk;
	logic rst;
	logic cmd_valid;
	logic cmd_read;
	logic [9:0] cmd_addr;
	logic [15:0] cmd_wdata;
	logic cmd_ready_q;
	logic rd_valid;
	logic rd_ready;
	logic [15:0] rd_data;
	logic nack_err_q;
	logic [9:0] reg_addr_q;
	logic [15:0] reg_wdata_q;
	logic reg_wr_q;
	logic reg_rd_q;
	logic [15:0] reg_rdata;
	logic [15:0] mem [1024];
	logic [15:0] em [1024];
	logic [31:0] exp_wr [$];
	logic [31:0] exp_rd [$];
	logic [31:0] exp_ra [$];
	logic [31:0] rnd;
	logic [9:0] wa;
	int miscompares;
	int checks;
	int n;

	tcp_bus_if tcp_bus_if_inst ();
	tcp_dev_end tcp_dev_end_inst (.core_clk(core_clk), .rst(rst), .bus(tcp_bus_if_inst),
		.reg_addr_q(reg_addr_q), .reg_wdata_q(reg_wdata_q), .reg_wr_q(reg_wr_q),
		.reg_rd_q(reg_rd_q), .reg_rdata(reg_rdata));
	tcp_host_end tcp_host_end_inst (.core_clk(core_clk), .rst(rst), .bus(tcp_bus_if_inst),
		.cmd_valid(cmd_valid), .cmd_ready_q(cmd_ready_q), .cmd_read(cmd_read),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rd_valid(rd_valid),
		.rd_ready(rd_ready), .rd_data(rd_data), .nack_err_q(nack_err_q));
	tcp_bus_asserts tcp_bus_asserts_inst (.core_clk(core_clk), .rst(rst),
		.host_scl_o(tcp_bus_if_inst.host_scl_o), .host_scl_oe(tcp_bus_if_inst.host_scl_oe),
		.host_sda_o(tcp_bus_if_inst.host_sda_o), .host_sda_oe(tcp_bus_if_inst.host_sda_oe),
		.dev_sda_o(tcp_bus_if_inst.dev_sda_o), .dev_sda_oe(tcp_bus_if_inst.dev_sda_oe),
		.scl(tcp_bus_if_inst.scl), .sda(tcp_bus_if_inst.sda));

	////////////////////////////////////////////////////////////////////////////////
	// Register back end keeps written values
	assign reg_rdata = mem[reg_addr_q];
	always @(posedge core_clk) begin
		if (reg_wr_q === 1'b1) mem[reg_addr_q] <= reg_wdata_q;
	end

	// Clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out;
		$display("Counts: checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// Wait for idle, then offer one command and note its results
	task automatic run_cmd(input logic rd, input logic [9:0] a, input logic [15:0] d);
		int k;
		k = 0;
		@(negedge core_clk);
		while (cmd_ready_q !== 1'b1 && k < 30000) begin
			@(negedge core_clk);
			k++;
		end
		check(32'(cmd_ready_q), 32'h1);
		if (rd) exp_ra.push_back(32'(a));
		if (rd) exp_rd.push_back(32'(em[a]));
		else exp_wr.push_back(32'({a, d}));
		if (!rd) em[a] = d;
		cmd_read = rd;
		cmd_addr = a;
		cmd_wdata = d;
		cmd_valid = 1'b1;
		@(negedge core_clk);
		cmd_valid = 1'b0;
		rnd = xs(rnd);
		cmd_addr = rnd[9:0];
		cmd_wdata = rnd[31:16];
		check(32'(cmd_ready_q), 32'h0);
	endtask

	// Result monitor, settled after the falling edge
	initial forever begin
		@(negedge core_clk);
		#1;
		if (rst === 1'b0) begin
			if (reg_wr_q === 1'b1)
				check(32'({reg_addr_q, reg_wdata_q}), exp_wr.size() ? exp_wr.pop_front() : '1);
			if (rd_valid === 1'b1 && rd_ready === 1'b1)
				check(32'(rd_data), exp_rd.size() ? exp_rd.pop_front() : '1);
			if (reg_rd_q === 1'b1)
				check(32'(reg_addr_q), exp_ra.size() ? exp_ra.pop_front() : '1);
			if (nack_err_q !== 1'b0) check(32'(nack_err_q), 32'h0);
		end
	end

	// Watchdog
	initial begin
		repeat (90000) @(posedge core_clk);
		miscompares++;
		close_out();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		miscompares = 0;
		checks = 0;
		rnd = 32'h8c94a977;
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_read = 1'b0;
		cmd_addr = 10'h000;
		cmd_wdata = 16'h0000;
		rd_ready = 1'b0;
		for (int i = 0; i < 1024; i++) begin
			mem[i] = 16'(i * 40503);
			em[i] = 16'(i * 40503);
		end
		repeat (16) @(negedge core_clk);
		rst = 1'b0;
		rnd = xs(rnd);
		wa = rnd[9:0];
		run_cmd(1'b0, wa, rnd[31:16]);
		rnd = xs(rnd);
		run_cmd(1'b0, 10'h3ff, rnd[15:0]);
		run_cmd(1'b1, wa, 16'h0000);
		run_cmd(1'b1, 10'h3ff, 16'h0000);
		rnd = xs(rnd);
		run_cmd(1'b1, rnd[9:0], 16'h0000);
		n = 0;
		while (cmd_ready_q !== 1'b1 && n < 30000) begin
			@(negedge core_clk);
			n++;
		end
		check(32'(rd_valid), 32'h1);
		rd_ready = 1'b1;
		n = 0;
		while (rd_valid !== 1'b0 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		check(32'(rd_valid), 32'h0);
		check(32'(exp_wr.size() + exp_rd.size() + exp_ra.size()), 32'h0);
		close_out();
	end
endmodule // tb
